//--- hw/mpad_pkg.sv
// Constants and types shared by the management port address decoder
package mpad_pkg;
  // Serial frame layout
  localparam int unsigned PREAMBLE_LEN = 32;
  localparam int unsigned HDR_BITS     = 12;
  localparam int unsigned TA_BITS      = 2;
  localparam int unsigned DATA_BITS    = 16;
  // Header field positions within the 12 header bits: op, port field, register field
  localparam int unsigned HDR_OP_MSB   = 11;
  localparam int unsigned HDR_OP_LSB   = 10;
  localparam int unsigned HDR_PA_MSB   = 9;
  localparam int unsigned HDR_PA_LSB   = 5;
  localparam int unsigned HDR_REG_MSB  = 4;
  localparam int unsigned HDR_REG_LSB  = 0;
  // Upper port bits that are matched, and the channel bits
  localparam int unsigned PA_MATCH_MSB = 4;
  localparam int unsigned PA_MATCH_LSB = 2;
  localparam int unsigned PA_CHAN_MSB  = 1;
  localparam int unsigned PA_CHAN_LSB  = 0;
  localparam int unsigned PA_TIMER_BIT = 1;
  // Second start bit: one for the short format, zero for the extended format
  localparam logic       ST2_C22      = 1'h1;
  localparam logic       ST2_C45      = 1'h0;
  // Op codes
  localparam logic [1:0] OP22_WRITE   = 2'h1;
  localparam logic [1:0] OP22_READ    = 2'h2;
  localparam logic [1:0] OP45_ADDR    = 2'h0;
  localparam logic [1:0] OP45_WRITE   = 2'h1;
  localparam logic [1:0] OP45_RDINC   = 2'h2;
  localparam logic [1:0] OP45_READ    = 2'h3;
  // Channel codes
  localparam logic [1:0] CHAN_A       = 2'h0;
  localparam logic [1:0] CHAN_B       = 2'h1;
  localparam logic [1:0] CHAN_C       = 2'h2;
  localparam logic [1:0] CHAN_D       = 2'h3;
  // Reset hold that the board must give, and its cycles at 200 MHz
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned RESET_HOLD_NS  = 10000;
  localparam int unsigned RESET_HOLD_CYC =
    (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Values after reset
  localparam logic [5:0]  ONES_RST     = 6'h00;
  localparam logic [4:0]  CNT_RST      = 5'h00;
  localparam logic [15:0] WORD_RST     = 16'h0000;

  typedef enum logic [2:0] {
    MPAD_IDLE,
    MPAD_START,
    MPAD_HDR,
    MPAD_TA,
    MPAD_DATA
  } mpad_state_t;
endpackage : mpad_pkg

//--- hw/mpad_smp_if.sv
// Carrier between the line sampler and the frame decoder
interface mpad_smp_if;
  logic        rise;
  logic        fall;
  logic        bit_v;
  logic [15:0] word;
  modport src (output rise, output fall, output bit_v, output word);
  modport dst (input rise, input fall, input bit_v, input word);
endinterface : mpad_smp_if

//--- hw/mpad_sampler.sv
// Management clock edge finder and serial shift register
module mpad_sampler (
  input  wire logic   clk,
  input  wire logic   rst_b,
  input  wire logic   mdc,
  input  wire logic   mdio_in,
  mpad_smp_if.src     smp
);
  import mpad_pkg::*;

  typedef struct packed {
    logic        mdc_q;
    logic        rise;
    logic        fall;
    logic        bit_v;
    logic [15:0] word;
  } mpad_smp_st_t;

  mpad_smp_st_t s_q;
  mpad_smp_st_t s_d;

  // Edge detection; the line is sampled and shifted on the rising edge
  always_comb begin
    s_d       = s_q;
    s_d.mdc_q = mdc;
    s_d.rise  = mdc & ~s_q.mdc_q;
    s_d.fall  = ~mdc & s_q.mdc_q;
    if (mdc && !s_q.mdc_q) begin
      s_d.bit_v = mdio_in;
      s_d.word  = {s_q.word[14:0], mdio_in};
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{mdc_q: 1'b0, rise: 1'b0, fall: 1'b0, bit_v: 1'b0, word: WORD_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign smp.rise  = s_q.rise;
  assign smp.fall  = s_q.fall;
  assign smp.bit_v = s_q.bit_v;
  assign smp.word  = s_q.word;
endmodule : mpad_sampler

//--- hw/mpad_top.sv
// Management port frame decoder with port address match and pin state control
// Contract
// - Answer a frame only when port field bits 4:2 equal strapped bits 4:2.
// - Port field bits 1:0 select channel A, B, C or D.
// - Strap bit 1 is not matched; it feeds the stopwatch timer function.
// - Data line and test data output float during reset.
// - Register power down keeps the management port fully working.
// - Status bits of stopped clocks may read indeterminate in power down.
// - Pin power down of all four channels floats the data line; register power down does not.
// - Test data output floats when unused and in either power down.
// - Test input pull-ups off in pin power down, on in register power down.
// - Format strap: high short format, low extended; taken at hard or soft reset.
module mpad_top (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                soft_rst,
  input  wire logic                mdc,
  input  wire logic                mdio_in,
  output logic                     mdio_out,
  output logic                     mdio_oe,
  input  wire logic [4:0]          port_addr_straps,
  input  wire logic                frame_format_strap,
  input  wire logic                chan_a_pin_powerdown_b,
  input  wire logic                chan_b_pin_powerdown_b,
  input  wire logic                chan_c_pin_powerdown_b,
  input  wire logic                chan_d_pin_powerdown_b,
  input  wire logic [3:0]          chan_reg_powerdown,
  input  wire logic                tap_active,
  input  wire logic                tap_tdo,
  output logic                     tdo_out,
  output logic                     tdo_oe,
  output logic                     tdi_pullup_en,
  output logic                     tms_pullup_en,
  output logic                     stopwatch_strap,
  output logic                     fmt_c22,
  output logic [3:0]               status_reliable,
  output logic                     acc_rd,
  output logic                     acc_wr,
  output logic                     acc_addr,
  output logic [1:0]               acc_chan,
  output logic [3:0]               acc_chan_sel,
  output logic [4:0]               acc_reg,
  output logic [15:0]              acc_wdata,
  input  wire logic [15:0]         rd_data
);
  import mpad_pkg::*;

  typedef struct packed {
    mpad_state_t state;
    logic [5:0]  ones;
    logic [4:0]  cnt;
    logic        captured;
    logic        fmt_c22;
    logic [2:0]  pa_match;
    logic        stopwatch;
    logic        hit;
    logic        rd_hit;
    logic        wr_hit;
    logic        addr_hit;
    logic [15:0] tx;
    logic        mdio_out;
    logic        mdio_oe;
    logic        tdo_out;
    logic        tdo_oe;
    logic        pullup_en;
    logic [3:0]  reliable;
    logic        acc_rd;
    logic        acc_wr;
    logic        acc_addr;
    logic [1:0]  acc_chan;
    logic [3:0]  acc_chan_sel;
    logic [4:0]  acc_reg;
    logic [15:0] acc_wdata;
  } mpad_top_st_t;

  // One-hot channel select from the two low port bits
  function automatic logic [3:0] chan_onehot(input logic [1:0] code);
    logic [3:0] oh;
    oh = 4'h0;
    case (code)
      CHAN_A:  oh = 4'h1;
      CHAN_B:  oh = 4'h2;
      CHAN_C:  oh = 4'h4;
      CHAN_D:  oh = 4'h8;
      default: oh = 4'h0;
    endcase
    return oh;
  endfunction : chan_onehot

  mpad_smp_if   smp ();
  mpad_top_st_t s_q;
  mpad_top_st_t s_d;
  logic [3:0]   pin_pd;
  logic         all_pin_pd;
  logic         all_reg_pd;
  logic [1:0]   hdr_op;
  logic [4:0]   hdr_pa;
  logic         is_rd;
  logic         is_wr;
  logic         is_addr;

  // Line sampler on the management clock edges
  mpad_sampler u_sampler (
    .clk     (clk),
    .rst_b   (rst_b),
    .mdc     (mdc),
    .mdio_in (mdio_in),
    .smp     (smp)
  );

  // Power down summaries and header fields
  assign pin_pd     = {~chan_d_pin_powerdown_b, ~chan_c_pin_powerdown_b,
                       ~chan_b_pin_powerdown_b, ~chan_a_pin_powerdown_b};
  assign all_pin_pd = &pin_pd;
  assign all_reg_pd = &chan_reg_powerdown;
  assign hdr_op     = smp.word[HDR_OP_MSB:HDR_OP_LSB];
  assign hdr_pa     = smp.word[HDR_PA_MSB:HDR_PA_LSB];

  // Op decode for the format that was strapped
  always_comb begin
    is_rd   = 1'b0;
    is_wr   = 1'b0;
    is_addr = 1'b0;
    if (s_q.fmt_c22) begin
      is_rd = (hdr_op == OP22_READ);
      is_wr = (hdr_op == OP22_WRITE);
    end else begin
      is_rd   = (hdr_op == OP45_READ) || (hdr_op == OP45_RDINC);
      is_wr   = (hdr_op == OP45_WRITE);
      is_addr = (hdr_op == OP45_ADDR);
    end
  end

  // Next state: strap capture, frame walk, pin control
  always_comb begin
    s_d          = s_q;
    s_d.acc_rd   = 1'b0;
    s_d.acc_wr   = 1'b0;
    s_d.acc_addr = 1'b0;

    // Straps caught after hard reset release or on soft reset
    if (!s_q.captured || soft_rst) begin
      s_d.captured  = 1'b1;
      s_d.fmt_c22   = frame_format_strap;
      s_d.pa_match  = port_addr_straps[PA_MATCH_MSB:PA_MATCH_LSB];
      s_d.stopwatch = port_addr_straps[PA_TIMER_BIT];
      s_d.state     = MPAD_IDLE;
      s_d.ones      = ONES_RST;
    end else if (smp.rise) begin
      // Frame walk on sampled bits
      case (s_q.state)
        MPAD_IDLE: begin
          if (smp.bit_v) begin
            if (s_q.ones != 6'(PREAMBLE_LEN)) begin
              s_d.ones = s_q.ones + 6'h01;
            end
          end else begin
            if (s_q.ones == 6'(PREAMBLE_LEN)) begin
              s_d.state = MPAD_START;
            end
            s_d.ones = ONES_RST;
          end
        end
        MPAD_START: begin
          if (smp.bit_v == (s_q.fmt_c22 ? ST2_C22 : ST2_C45)) begin
            s_d.state = MPAD_HDR;
            s_d.cnt   = CNT_RST;
          end else begin
            s_d.state = MPAD_IDLE;
          end
        end
        MPAD_HDR: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == 5'(HDR_BITS - 1)) begin
            s_d.hit      = (hdr_pa[PA_MATCH_MSB:PA_MATCH_LSB] == s_q.pa_match);
            s_d.rd_hit   = s_d.hit & is_rd;
            s_d.wr_hit   = s_d.hit & is_wr;
            s_d.addr_hit = s_d.hit & is_addr;
            s_d.acc_rd   = s_d.rd_hit;
            s_d.acc_chan = hdr_pa[PA_CHAN_MSB:PA_CHAN_LSB];
            s_d.acc_chan_sel = chan_onehot(hdr_pa[PA_CHAN_MSB:PA_CHAN_LSB]);
            s_d.acc_reg  = smp.word[HDR_REG_MSB:HDR_REG_LSB];
            s_d.state    = MPAD_TA;
            s_d.cnt      = CNT_RST;
          end
        end
        MPAD_TA: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == 5'h00) begin
            s_d.tx = rd_data;
          end
          if (s_q.cnt == 5'(TA_BITS - 1)) begin
            s_d.state = MPAD_DATA;
            s_d.cnt   = CNT_RST;
          end
        end
        MPAD_DATA: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == 5'(DATA_BITS - 1)) begin
            s_d.acc_wr    = s_q.wr_hit;
            s_d.acc_addr  = s_q.addr_hit;
            s_d.acc_wdata = smp.word;
            s_d.state     = MPAD_IDLE;
            s_d.ones      = ONES_RST;
            s_d.rd_hit    = 1'b0;
          end
        end
        default: begin
          s_d.state = MPAD_IDLE;
        end
      endcase
    end

    // Read data changes after the falling edge so the controller samples it stably
    if (smp.fall) begin
      if (s_q.rd_hit && s_q.state == MPAD_TA && s_q.cnt == 5'h01) begin
        s_d.mdio_oe  = 1'b1;
        s_d.mdio_out = 1'b0;
      end else if (s_q.rd_hit && s_q.state == MPAD_DATA) begin
        s_d.mdio_oe  = 1'b1;
        s_d.mdio_out = s_q.tx[15];
        s_d.tx       = {s_q.tx[14:0], 1'b0};
      end else begin
        s_d.mdio_oe  = 1'b0;
      end
    end
    // Pin power down of all four channels floats the line; register power down leaves it alone
    if (all_pin_pd) begin
      s_d.mdio_oe = 1'b0;
    end

    // Test data output and pull-ups
    s_d.tdo_oe    = tap_active & ~all_pin_pd & ~all_reg_pd;
    s_d.tdo_out   = tap_tdo;
    s_d.pullup_en = ~all_pin_pd;
    // Status from channels with stopped clocks is flagged unreliable
    s_d.reliable  = ~(pin_pd | chan_reg_powerdown);
  end

  // State register; reset floats both driven pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{state: MPAD_IDLE, ones: ONES_RST, cnt: CNT_RST, captured: 1'b0,
               fmt_c22: 1'b0, pa_match: 3'h0, stopwatch: 1'b0, hit: 1'b0,
               rd_hit: 1'b0, wr_hit: 1'b0, addr_hit: 1'b0, tx: WORD_RST,
               mdio_out: 1'b0, mdio_oe: 1'b0, tdo_out: 1'b0, tdo_oe: 1'b0,
               pullup_en: 1'b0, reliable: 4'h0, acc_rd: 1'b0, acc_wr: 1'b0,
               acc_addr: 1'b0, acc_chan: CHAN_A, acc_chan_sel: 4'h0,
               acc_reg: 5'h00, acc_wdata: WORD_RST};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign mdio_out        = s_q.mdio_out;
  assign mdio_oe         = s_q.mdio_oe;
  assign tdo_out         = s_q.tdo_out;
  assign tdo_oe          = s_q.tdo_oe;
  assign tdi_pullup_en   = s_q.pullup_en;
  assign tms_pullup_en   = s_q.pullup_en;
  assign stopwatch_strap = s_q.stopwatch;
  assign fmt_c22         = s_q.fmt_c22;
  assign status_reliable = s_q.reliable;
  assign acc_rd          = s_q.acc_rd;
  assign acc_wr          = s_q.acc_wr;
  assign acc_addr        = s_q.acc_addr;
  assign acc_chan        = s_q.acc_chan;
  assign acc_chan_sel    = s_q.acc_chan_sel;
  assign acc_reg         = s_q.acc_reg;
  assign acc_wdata       = s_q.acc_wdata;
endmodule : mpad_top

//--- bench/mpad_chk.sv
// Checker of pin states and strap captures on the management port decoder
module mpad_chk (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       soft_rst,
  input wire logic       mdio_out,
  input wire logic       mdio_oe,
  input wire logic [4:0] port_addr_straps,
  input wire logic       frame_format_strap,
  input wire logic       chan_a_pin_powerdown_b,
  input wire logic       chan_b_pin_powerdown_b,
  input wire logic       chan_c_pin_powerdown_b,
  input wire logic       chan_d_pin_powerdown_b,
  input wire logic [3:0] chan_reg_powerdown,
  input wire logic       tap_active,
  input wire logic       tap_tdo,
  input wire logic       tdo_out,
  input wire logic       tdo_oe,
  input wire logic       tdi_pullup_en,
  input wire logic       tms_pullup_en,
  input wire logic       stopwatch_strap,
  input wire logic       fmt_c22,
  input wire logic [3:0] status_reliable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Power down summaries
  wire [3:0] pin_pd = ~{chan_d_pin_powerdown_b, chan_c_pin_powerdown_b,
                        chan_b_pin_powerdown_b, chan_a_pin_powerdown_b};
  wire       allpin = &pin_pd;
  wire       allreg = &chan_reg_powerdown;
  wire [3:0] pdv    = pin_pd | chan_reg_powerdown;

  property p_rst_float;
    $rose(rst_b) |-> !mdio_oe && !tdo_oe;
  endproperty
  a_rst_float: assert property (p_rst_float) else $error("Pins driven in reset");
  property p_pin_float;
    allpin ##1 allpin |-> !mdio_oe;
  endproperty
  a_pin_float: assert property (p_pin_float) else $error("Data line driven");
  property p_tdo_en;
    $past(rst_b) && $stable({tap_active, allpin, allreg})
      |-> tdo_oe == (tap_active && !allpin && !allreg);
  endproperty
  a_tdo_en: assert property (p_tdo_en) else $error("Test output enable wrong");
  property p_tdo_data;
    $past(rst_b) |-> tdo_out == $past(tap_tdo);
  endproperty
  a_tdo_data: assert property (p_tdo_data) else $error("Test data output wrong");
  property p_pullup;
    $past(rst_b) && $stable(allpin) |-> tdi_pullup_en == !allpin && tms_pullup_en == !allpin;
  endproperty
  a_pullup: assert property (p_pullup) else $error("Pull-up enable wrong");
  property p_fmt;
    $past(rst_b) && !soft_rst && $stable(frame_format_strap) ##1 !soft_rst
      |-> fmt_c22 == frame_format_strap;
  endproperty
  a_fmt: assert property (p_fmt) else $error("Format capture wrong");
  property p_swatch;
    $past(rst_b) && !soft_rst ##1 !soft_rst |-> stopwatch_strap == port_addr_straps[1];
  endproperty
  a_swatch: assert property (p_swatch) else $error("Timer strap wrong");
  property p_ta_zero;
    $rose(mdio_oe) |-> !mdio_out ##1 (mdio_oe && !mdio_out) [*3];
  endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("Turnaround drive wrong");
  property p_status;
    $past(rst_b) && $stable(pdv) |-> status_reliable == ~pdv;
  endproperty
  a_status: assert property (p_status) else $error("Status validity wrong");
endmodule : mpad_chk

bind mpad_top mpad_chk i_chk (.clk, .rst_b, .soft_rst, .mdio_out, .mdio_oe, .port_addr_straps,
  .frame_format_strap, .chan_a_pin_powerdown_b, .chan_b_pin_powerdown_b, .chan_c_pin_powerdown_b,
  .chan_d_pin_powerdown_b, .chan_reg_powerdown, .tap_active, .tdo_oe, .tdi_pullup_en,
  .tms_pullup_en, .stopwatch_strap, .fmt_c22, .status_reliable, .tap_tdo, .tdo_out);

//--- bench/mpad_sta.sv
// Station management controller model on the pulled-up management line
module mpad_sta (
  input  wire logic clk,
  input  wire logic mdio_oe,
  input  wire logic mdio_out,
  output logic      mdc,
  output logic      mdio_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sta_oe = 1'h0;
  logic sta_d  = 1'h1;
  initial mdc = 1'h0;
  // Line level: a driver, else the board pull-up
  assign mdio_in = mdio_oe ? mdio_out : (sta_oe ? sta_d : 1'h1);

  // One whole frame; the clock rests low between frames, h sets the pace
  task automatic frame(input logic [13:0] hdr, input logic [15:0] wd, input logic rd,
                       input int h, output logic [15:0] q);
    logic [63:0] f;
    f = {32'hFFFFFFFF, hdr, rd ? 2'h3 : 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      @(posedge clk);
      mdc    <= 1'h0;
      sta_oe <= !(rd && i < 18);
      sta_d  <= f[i];
      repeat (h) @(posedge clk);
      if (i < 16) q[i] = mdio_in;
      mdc <= 1'h1;
      repeat (h) @(posedge clk);
    end
    @(posedge clk);
    mdc    <= 1'h0;
    sta_oe <= 1'h0;
    repeat (h) @(posedge clk);
  endtask : frame
endmodule : mpad_sta

//--- bench/mpad_top_bench.sv
// Self-checking bench of the management port decoder
module mpad_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import mpad_pkg::*;
  logic        clk = 1'h0, rst_b = 1'h0, soft_rst = 1'h0, frame_format_strap = 1'h1;
  logic        tap_active = 1'h0, tap_tdo = 1'h0, mdc, mdio_in, mdio_out, mdio_oe;
  logic        tdo_out, tdo_oe, tdi_pullup_en, tms_pullup_en, stopwatch_strap, fmt_c22;
  logic        acc_rd, acc_wr, acc_addr;
  logic [4:0]  port_addr_straps = 5'h16; // Distinct upper bits, low bit tied low
  logic [3:0]  pin_pd_b = 4'hF, chan_reg_powerdown = 4'h0, status_reliable, acc_chan_sel, s_sel;
  logic [1:0]  acc_chan, s_chan;
  logic [4:0]  acc_reg, s_reg;
  logic [15:0] acc_wdata, s_wd, rd_data = 16'h0000;
  logic [2:0]  seen = 3'h0;
  int          seed = 32'h78979505, n_fail = 0, comparisons = 0, cycles = 0;

  mpad_top i_dut (.clk, .rst_b, .soft_rst, .mdc, .mdio_in, .mdio_out, .mdio_oe, .port_addr_straps,
    .frame_format_strap, .chan_a_pin_powerdown_b(pin_pd_b[0]), .chan_b_pin_powerdown_b(pin_pd_b[1]),
    .chan_c_pin_powerdown_b(pin_pd_b[2]), .chan_d_pin_powerdown_b(pin_pd_b[3]), .chan_reg_powerdown,
    .tap_active, .tap_tdo, .tdo_out, .tdo_oe, .tdi_pullup_en, .tms_pullup_en, .stopwatch_strap,
    .fmt_c22, .status_reliable, .acc_rd, .acc_wr, .acc_addr, .acc_chan, .acc_chan_sel, .acc_reg,
    .acc_wdata, .rd_data);
  mpad_sta i_sta (.clk, .mdio_oe, .mdio_out, .mdc, .mdio_in);

  always #2.5 clk = ~clk;
  // Random test port traffic and the hang limit
  always @(posedge clk) begin
    tap_active <= 1'($random(seed));
    tap_tdo    <= 1'($random(seed));
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      complete_run();
    end
  end
  // Latch access pulses and what they carry
  always @(posedge clk) if (acc_rd | acc_wr | acc_addr) begin
    seen   <= seen | {acc_addr, acc_wr, acc_rd};
    s_chan <= acc_chan;
    s_sel  <= acc_chan_sel;
    s_reg  <= acc_reg;
    s_wd   <= acc_wdata;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // Expected pulse: bit0 read, bit1 write, bit2 address
  function automatic logic [2:0] kind(input logic st2, input logic [1:0] op);
    if (st2 == ST2_C22) return (op == OP22_READ) ? 3'h1 : 3'h2;
    return (op == OP45_ADDR) ? 3'h4 : (op == OP45_WRITE) ? 3'h2 : 3'h1;
  endfunction : kind

  // One frame through the station model and its expected outcome
  task automatic run(input logic st2, input logic [1:0] op, input logic [4:0] pa);
    logic [4:0]  rg;
    logic [15:0] wd, rv, q;
    logic [2:0]  k;
    logic        hit;
    rg  = 5'($random(seed));
    wd  = 16'($random(seed));
    rv  = 16'($random(seed));
    k   = kind(st2, op);
    hit = pa[4:2] == port_addr_straps[4:2] && st2 == frame_format_strap;
    rd_data <= rv;
    seen = 3'h0;
    i_sta.frame({1'h0, st2, op, pa, rg}, wd, k == 3'h1, 4 + 3 * pa[0], q);
    check(32'(seen), hit ? 32'(k) : 32'h0);
    check(32'(q), k != 3'h1 ? 32'(wd) : hit && pin_pd_b != 4'h0 ? 32'(rv) : 32'hFFFF);
    if (hit) check(32'({s_chan, s_reg}), 32'({pa[1:0], rg}));
    if (hit) check(32'(s_sel), 32'(4'h1 << pa[1:0]));
    if (hit && k == 3'h2) check(32'(s_wd), 32'(wd));
  endtask : run

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    check(32'({stopwatch_strap, fmt_c22}), 32'({port_addr_straps[1], 1'h1}));
    // Short format: all channels, mismatches, pin and register power down
    for (int i = 0; i < 14; i++) begin
      logic [4:0] pa;
      logic [1:0] op;
      @(posedge clk);
      pin_pd_b           <= (i == 4) ? 4'h0 : 4'hF;
      chan_reg_powerdown <= (i == 6 || i == 8) ? 4'hF : 4'($random(seed));
      pa = 5'($random(seed));
      if (!i[0]) pa = {port_addr_straps[4:2], 2'(i >> 1)};
      op = ($random(seed) & 1 || i == 6) ? OP22_READ : OP22_WRITE;
      if (i == 8) op = OP22_WRITE;
      run(ST2_C22, op, pa);
    end
    // Extended format after a soft reset, then a refused short frame
    @(posedge clk);
    frame_format_strap <= 1'h0;
    soft_rst           <= 1'h1;
    @(posedge clk);
    soft_rst <= 1'h0;
    for (int k = 0; k < 4; k++) run(ST2_C45, 2'(k), {port_addr_straps[4:2], 2'(k)});
    run(ST2_C22, OP22_READ, {port_addr_straps[4:2], 2'h0});
    // Hard reset in mid-run: pins float, straps taken again, decode resumes
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (RESET_HOLD_CYC) @(posedge clk);
    check(32'({mdio_oe, tdo_oe}), 32'h0);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    check(32'({stopwatch_strap, fmt_c22}), 32'({port_addr_straps[1], 1'h0}));
    run(ST2_C45, OP45_WRITE, {port_addr_straps[4:2], 2'h3});
    complete_run();
  end
endmodule : mpad_top_bench
